// >>> rtl/bert_ext_params.svh
// Offsets, field positions, reset values and counts for the tester status block.
// Assumes a 32-bit word-addressed bus: byte address is four times the index.
`ifndef BERT_EXT_PARAMS_SVH
`define BERT_EXT_PARAMS_SVH

// ==========================================
// Register indices
`define IDX_CTRL 14'h1400
`define IDX_LIVE 14'h1401
`define IDX_LAT1 14'h1402
`define IDX_MASK1 14'h1403
`define IDX_LAT2 14'h1404
`define IDX_MASK2 14'h1405
`define IDX_ERRC0 14'h1406
`define IDX_ERRC1 14'h1407
`define IDX_ERRC2 14'h1408

// ==========================================
// Fields and reset values
`define CTRL_ALIGN_BIT 0
`define CTRL_P55_BIT 1
`define CTRL_MASK 8'h03
`define MASK2_MASK 8'h07
`define REG_RESET 8'h00
`define P55_PATTERN_CODE 4'hf

// ==========================================
// Counts
`define RUN_LEN 6'd32

`endif

// >>> rtl/bert_ext_pkg.sv
// Types shared by the tester status block and its bench.
// Assumes bert_ext_params.svh is visible for field layouts.
package bert_ext_pkg;

  // ==========================================
  // Receive checker states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_SYNC
  } sync_state_e;

  // ==========================================
  // One received bit from the checker
  typedef struct packed {
    logic valid;
    logic data;
    logic match;
  } rx_bit_s;

  // ==========================================
  // Whole block state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] lat1;
    logic [7:0] lat2;
    logic [3:0] live;
    logic [5:0] ones_cnt;
    logic [5:0] zeros_cnt;
    logic [5:0] match_cnt;
    sync_state_e state;
    logic [31:0] bit_cnt;
    logic [23:0] err_cnt;
    logic ack;
    logic [7:0] dat;
    logic irq;
    logic align;
    logic p55;
  } state_s;

endpackage

// >>> rtl/bert_extended_status_irq.sv
// Extended control, live status, latched events and interrupt masks of one tester port.
// Assumes a classic Wishbone master and a checker that flags each received bit and match.
//
// Added by the designer: register access over Wishbone.
`include "bert_ext_params.svh"
`timescale 1ns/1ps
`default_nettype none

module bert_extended_status_irq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire bert_ext_pkg::rx_bit_s rx_i,
  input wire logic search_start_i,
  input wire logic [3:0] pattern_select_field_i,
  output logic fifty_five_octet_select_o,
  output logic byte_boundary_align_o,
  output logic irq_o
);
  import bert_ext_pkg::*;

  state_s s;
  state_s n;
  logic hit;
  logic wr;
  logic [13:0] idx;
  logic [7:0] rd;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] set1;
  logic [7:0] set2;
  logic err;
  logic bit_wrap;
  logic err_wrap;
  logic rd_lat1;
  logic rd_lat2;
  logic wr_lat1;
  logic wr_lat2;
  logic [7:0] lat2_wmask;

  // ==========================================
  // Bus decode
  // Ack low gates a held request, so each access is taken once
  assign idx = adr_i[15:2];
  assign hit = cyc_i & stb_i & ~s.ack;
  assign wr = hit & we_i & sel_i[0];
  assign rd_lat1 = hit & ~we_i & (idx == `IDX_LAT1);
  assign rd_lat2 = hit & ~we_i & (idx == `IDX_LAT2);
  assign wr_lat1 = wr & (idx == `IDX_LAT1);
  assign wr_lat2 = wr & (idx == `IDX_LAT2);
  assign lat2_wmask = `MASK2_MASK;

  // ==========================================
  // Per-bit clear of latched events
  // Read returns then clears; a one written clears as well
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_clr
      assign clr1[g] = (rd_lat1 & s.lat1[g]) | (wr_lat1 & dat_i[g]);
      assign clr2[g] = (rd_lat2 & s.lat2[g]) | (wr_lat2 & dat_i[g] & lat2_wmask[g]);
    end
  endgenerate

  // ==========================================
  // Register read mux
  // Unmapped indices read zero
  always_comb begin
    unique case (idx)
      `IDX_CTRL: begin
        rd = s.ctrl;
      end
      `IDX_LIVE: begin
        rd = {4'h0, s.live};
      end
      `IDX_LAT1: begin
        rd = s.lat1;
      end
      `IDX_MASK1: begin
        rd = s.mask1;
      end
      `IDX_LAT2: begin
        rd = s.lat2;
      end
      `IDX_MASK2: begin
        rd = s.mask2;
      end
      `IDX_ERRC0: begin
        rd = s.err_cnt[7:0];
      end
      `IDX_ERRC1: begin
        rd = s.err_cnt[15:8];
      end
      `IDX_ERRC2: begin
        rd = s.err_cnt[23:16];
      end
      default: begin
        rd = 8'h00;
      end
    endcase
  end

  // ==========================================
  // Next state
  always_comb begin
    n = s;
    err = 1'b0;
    bit_wrap = 1'b0;
    err_wrap = 1'b0;
    n.ack = hit;
    n.align = 1'b0;

    // Read data holds until the next access
    if (hit) begin
      n.dat = we_i ? 8'h00 : rd;
    end

    // Live and counter registers ignore writes
    if (wr) begin
      unique case (idx)
        `IDX_CTRL: begin
          n.ctrl = dat_i[7:0] & `CTRL_MASK;
        end
        `IDX_MASK1: begin
          n.mask1 = dat_i[7:0];
        end
        `IDX_MASK2: begin
          n.mask2 = dat_i[7:0] & `MASK2_MASK;
        end
        default: begin
          n.ctrl = s.ctrl;
        end
      endcase
    end

    // A rising edge on the align bit gives one realign pulse
    n.align = n.ctrl[`CTRL_ALIGN_BIT] & ~s.ctrl[`CTRL_ALIGN_BIT];
    n.p55 = n.ctrl[`CTRL_P55_BIT] & (pattern_select_field_i == `P55_PATTERN_CODE);

    // ==========================================
    // Receive bit tracking
    if (rx_i.valid) begin
      if (rx_i.data) begin
        n.zeros_cnt = 6'd0;
        if (s.ones_cnt != `RUN_LEN) begin
          n.ones_cnt = s.ones_cnt + 6'd1;
        end
      end else begin
        n.ones_cnt = 6'd0;
        if (s.zeros_cnt != `RUN_LEN) begin
          n.zeros_cnt = s.zeros_cnt + 6'd1;
        end
      end
      unique case (s.state)
        ST_IDLE: begin
          n.state = s.state;
        end
        ST_SEARCH: begin
          if (!rx_i.match) begin
            n.match_cnt = 6'd0;
          end else if (s.match_cnt == `RUN_LEN - 6'd1) begin
            n.state = ST_SYNC;
          end else begin
            n.match_cnt = s.match_cnt + 6'd1;
          end
        end
        ST_SYNC: begin
          // Errors only mean something once the pattern is locked
          n.bit_cnt = s.bit_cnt + 32'h1;
          bit_wrap = &s.bit_cnt;
          if (!rx_i.match) begin
            err = 1'b1;
            n.err_cnt = s.err_cnt + 24'h1;
            err_wrap = &s.err_cnt;
          end
        end
        default: begin
          // Unused code falls back to idle
          n.state = ST_IDLE;
        end
      endcase
    end
    // A new search overrides any match progress this cycle
    if (search_start_i) begin
      n.state = ST_SEARCH;
      n.match_cnt = 6'd0;
    end

    n.live = {n.ones_cnt == `RUN_LEN, n.zeros_cnt == `RUN_LEN,
              n.state == ST_SEARCH, n.state == ST_SYNC};

    // ==========================================
    // Latched events; a set in the clearing cycle wins
    set1 = {s.live & ~n.live, n.live & ~s.live};
    set2 = {5'h00, err, bit_wrap, err_wrap};
    n.lat1 = (s.lat1 & ~clr1) | set1;
    n.lat2 = (s.lat2 & ~clr2) | set2;
    n.irq = |(n.lat1 & n.mask1) | |(n.lat2 & n.mask2);
  end

  // ==========================================
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign dat_o = {24'h000000, s.dat};
  assign ack_o = s.ack;
  assign irq_o = s.irq;
  assign byte_boundary_align_o = s.align;
  assign fifty_five_octet_select_o = s.p55;

endmodule

`default_nettype wire

// >>> verif/bert_ext_props.sv
// Checker: port timing of the tester status block.
// Assumes binding to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module bert_ext_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic ack_o,
  input wire bert_ext_pkg::rx_bit_s rx_i,
  input wire logic search_start_i,
  input wire logic [3:0] pattern_select_field_i,
  input wire logic fifty_five_octet_select_o,
  input wire logic byte_boundary_align_o,
  input wire logic irq_o
);
  import bert_ext_pkg::*;
  // ==========================================
  // Relations
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  ack_timely_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack unasked");
  p55_gate_a: assert property (
    fifty_five_octet_select_o |-> $past(pattern_select_field_i) == 4'hf) else $error("p55 bad field");
  align_pulse_a: assert property (
    byte_boundary_align_o |=> !byte_boundary_align_o) else $error("align long");
  align_cause_a: assert property (
    $rose(byte_boundary_align_o) |-> $past(we_i) || $past(we_i, 2)) else $error("align uncaused");
  irq_rise_a: assert property (
    $rose(irq_o) |-> $past(rx_i.valid || search_start_i || we_i)) else $error("irq uncaused");
  irq_fall_a: assert property (
    $fell(irq_o) |-> $past(cyc_i && stb_i)) else $error("irq dropped alone");
endmodule
bind bert_extended_status_irq bert_ext_props props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .rx_i,
  .search_start_i, .pattern_select_field_i, .fifty_five_octet_select_o, .byte_boundary_align_o, .irq_o);
`default_nettype wire

// >>> verif/bert_extended_status_irq_tb_top.sv
// Bench: bus reads queued, checked at ack.
// Assumes the partner feeds receive bits.
`timescale 1ns/1ps
`default_nettype none
module bert_extended_status_irq_tb_top;
  import bert_ext_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic ss = 1'h0, go = 1'h0, d = 1'h0, m = 1'h0, ack_o, p55, aln, irq_o;
  logic [15:0] adr = 16'h0000;
  logic [31:0] wd = 32'h0, dat_o, r = 32'h9aad58c5;
  logic [3:0] fs = 4'h0;
  logic [5:0] len = 6'h00;
  logic [7:0] q[$];
  rx_bit_s rx;
  int err_count = 0, checked = 0, cycles = 0, pulses = 0;
  always #4 clk_i = ~clk_i;
  bert_extended_status_irq uut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hf), .dat_i(wd), .dat_o, .ack_o, .rx_i(rx), .search_start_i(ss), .pattern_select_field_i(fs),
    .fifty_five_octet_select_o(p55), .byte_boundary_align_o(aln), .irq_o);
  rx_bit_source far (.clk_i, .go_i(go), .len_i(len), .data_i(d), .match_i(m), .rx_o(rx));
  // ==========================================
  // Tasks
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] rg(input int k);
    return 16'h5000 + 16'(4 * k);
  endfunction
  task test_done;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wb(input logic w, input int k, input logic [7:0] v);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= rg(k);
    wd <= {24'h0, v};
    do @(posedge clk_i); while (ack_o !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task rd(input int k, input logic [7:0] e);
    q.push_back(e);
    wb(1'h0, k, 8'h00);
  endtask
  task feed(input logic [5:0] n, input logic dv, input logic mv);
    @(posedge clk_i);
    go <= 1'h1;
    len <= n;
    d <= dv;
    m <= mv;
    @(posedge clk_i);
    go <= 1'h0;
    repeat (n) @(posedge clk_i);
  endtask
  task pulse;
    @(posedge clk_i);
    ss <= 1'h1;
    @(posedge clk_i);
    ss <= 1'h0;
  endtask
  task ci(input logic e);
    @(negedge clk_i);
    chk("irq", {7'h0, e}, {7'h0, irq_o});
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (aln === 1'h1) pulses++;
    if (ack_o === 1'h1 && we === 1'h0) chk("dat_o", q.pop_front(), dat_o[7:0]);
    if (cycles == 4000) begin
      err_count++;
      test_done;
    end
  end
  // ==========================================
  // Sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int k = 0; k < 9; k++) rd(k, 8'h00);
    rd(16, 8'h00);
    for (int k = 0; k < 4; k++) begin
      r = xs(r);
      wb(1'h1, 3, r[7:0]);
      rd(3, r[7:0]);
      wb(1'h1, 5, r[15:8]);
      rd(5, r[15:8] & 8'h07);
    end
    wb(1'h1, 3, 8'h00);
    pulse;
    ci(1'h0);
    rd(1, 8'h02);
    rd(2, 8'h02);
    wb(1'h1, 3, 8'hff);
    wb(1'h1, 5, 8'h07);
    wb(1'h1, 0, 8'hff);
    rd(0, 8'h03);
    fs <= 4'hf;
    repeat (3) @(negedge clk_i);
    chk("p55", 8'h01, {7'h0, p55});
    feed(6'd31, 1'h1, 1'h0);
    rd(1, 8'h02);
    feed(6'd1, 1'h1, 1'h0);
    rd(1, 8'h0a);
    ci(1'h1);
    rd(2, 8'h08);
    ci(1'h0);
    feed(6'd32, 1'h0, 1'h0);
    rd(1, 8'h06);
    rd(2, 8'h84);
    feed(6'd32, 1'h1, 1'h1);
    rd(1, 8'h09);
    rd(2, 8'h69);
    feed(6'd1, 1'h1, 1'h0);
    ci(1'h1);
    rd(4, 8'h04);
    rd(6, 8'h01);
    pulse;
    wb(1'h1, 2, 8'h10);
    rd(2, 8'h02);
    feed(6'd1, 1'h1, 1'h0);
    rd(4, 8'h00);
    wb(1'h1, 0, 8'h00);
    wb(1'h1, 0, 8'h01);
    repeat (3) @(posedge clk_i);
    chk("align", 8'h02, pulses[7:0]);
    test_done;
  end
endmodule
`default_nettype wire

// >>> verif/rx_bit_source.sv
// Partner: receive checker stand-in, one bit a cycle.
// Assumes a one-cycle go pulse starts each run.
`timescale 1ns/1ps
`default_nettype none
module rx_bit_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [5:0] len_i,
  input wire logic data_i,
  input wire logic match_i,
  output var bert_ext_pkg::rx_bit_s rx_o
);
  import bert_ext_pkg::*;
  logic [5:0] left_r = 6'h00;
  // ==========================================
  // Idle data flipped, never stale
  always_ff @(posedge clk_i) begin
    if (go_i) left_r <= len_i;
    else if (left_r != 6'h00) left_r <= left_r - 6'h01;
  end
  assign rx_o = '{valid: left_r != 6'h00, data: (left_r != 6'h00) ~^ data_i, match: match_i};
endmodule
`default_nettype wire
